// ---- verilog/pls_link_status_rx.sv ----
// Contract
// RL1 - Start status only when pending and idle
// RL2 - Status code with first bits on D0-D1
// RL3 - Hold status code, end with idle
// RL4 - Two bits per cycle, 2 or 8 cycles
// RL5 - Full word on read or self-ID done
// RL6 - Flags delivered on send, register after all
// RL7 - Retry interrupted transfer until delivered
// RL8 - One idle cycle between status transfers
// RL9 - Word: flags 0-3, address 4-7, data 8-15
// RL10 - Interrupt flag from four events
// RL11 - Receive code with all-ones data-on
// RL12 - Receive may pre-empt status directly
// RL13 - Speed code one cycle, then hold receive
// RL14 - End receive with idle, hold one cycle
// RL15 - Null packet: data-on then idle only
// RL16 - At least one data-on cycle first
// RL17 - Speed code encodings, X zero, Y one
// RL18 - Link decodes speed on first non data-on
// RL19 - Forward every packet including own self-ID
// RL20 - Link keeps speed code out of CRC
// RL21 - Code 10b is receive phase
// RL22 - Code 00b is idle phase
// RL23 - Flags latch until sent, merge events
//
// Register access over AXI4-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module pls_link_status_rx (
  input  wire logic            aclk,
  input  wire logic            aresetn,
  input  wire pls_pkg::pls_ev_t ev,
  input  wire logic            rd_req,
  input  wire logic [3:0]      rd_addr,
  input  wire logic [7:0]      rd_data,
  input  wire logic            selfid_done,
  input  wire logic [7:0]      phyid_data,
  input  wire logic            rx_start,
  input  wire logic [1:0]      rx_speed,
  output logic                 rx_start_ready,
  input  wire logic            rx_valid,
  input  wire logic [7:0]      rx_byte,
  output logic                 rx_ready,
  input  wire logic            rx_end,
  output logic [1:0]           interface_phase_lines,
  output logic [7:0]           link_data,
  input  wire logic [31:0]     s_axi_awaddr,
  input  wire logic            s_axi_awvalid,
  output logic                 s_axi_awready,
  input  wire logic [31:0]     s_axi_wdata,
  input  wire logic [3:0]      s_axi_wstrb,
  input  wire logic            s_axi_wvalid,
  output logic                 s_axi_wready,
  output logic [1:0]           s_axi_bresp,
  output logic                 s_axi_bvalid,
  input  wire logic            s_axi_bready,
  input  wire logic [31:0]     s_axi_araddr,
  input  wire logic            s_axi_arvalid,
  output logic                 s_axi_arready,
  output logic [31:0]          s_axi_rdata,
  output logic [1:0]           s_axi_rresp,
  output logic                 s_axi_rvalid,
  input  wire logic            s_axi_rready
);
  // ****************************************
  // State
  // ****************************************
  logic [3:0]        flags_r;
  logic              reg_pend_r;
  logic [3:0]        reg_addr_r;
  logic [7:0]        reg_data_r;
  logic              st_act_r;
  logic [2:0]        st_cnt_r;
  logic [2:0]        st_last_r;
  logic [11:0]       sh_r;
  pls_pkg::pls_rst_t rstate_r;
  pls_pkg::pls_rst_t rstate_nxt;
  logic [7:0]        spd_r;
  logic [31:0]       ctrl_r;
  logic [31:0]       pkts_r;
  logic [1:0]        phase_nxt;
  logic [7:0]        d_nxt;
  logic [3:0]        flag_set;
  logic [3:0]        flag_clr;
  logic              st_go;
  logic              st_cont;
  logic              st_done;
  logic              rx_go;
  logic              byte_take;

  // Speed code drive, unused X bits at zero
  function automatic logic [7:0] spd_code(input logic [1:0] s);
    if (s == 2'h2) begin
      spd_code = pls_pkg::SPD_S400; // RL17
    end else if (s == 2'h1) begin
      spd_code = pls_pkg::SPD_S200;
    end else begin
      spd_code = pls_pkg::SPD_S100;
    end
  endfunction : spd_code

  // ****************************************
  // Status flags
  // ****************************************
  // Interrupt is the OR of four serial-bus events
  assign flag_set = {ev.cfg_to | ev.pwr_low | ev.state_to | ev.port_chg, // RL10
                     ev.bus_reset, ev.subact_gap, ev.arb_gap};           // RL9

  // A flag clears the cycle it is driven; a new event in that cycle wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_r <= 4'h0;
    end else begin
      flags_r <= (flags_r & ~flag_clr) | flag_set; // RL23 RL6
    end
  end

  // Register request; further requests are ignored until delivered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reg_pend_r <= 1'b0;
      reg_addr_r <= 4'h0;
      reg_data_r <= 8'h00;
    end else if (st_done) begin
      reg_pend_r <= 1'b0; // RL6
    end else if (!reg_pend_r && selfid_done) begin
      reg_pend_r <= 1'b1; // RL5
      reg_addr_r <= pls_pkg::PHYID_ADDR;
      reg_data_r <= phyid_data;
    end else if (!reg_pend_r && rd_req) begin
      reg_pend_r <= 1'b1; // RL5
      reg_addr_r <= rd_addr;
      reg_data_r <= rd_data;
    end
  end

  // ****************************************
  // Receive and status sequencing
  // ****************************************
  assign rx_go     = rx_start && rx_start_ready;
  assign byte_take = rx_valid && rx_ready;
  // Start only from an idle output cycle, so one idle sits between transfers
  assign st_go   = !st_act_r && ctrl_r[pls_pkg::CTRL_EN_B] && (|flags_r || reg_pend_r) // RL1 RL7
                   && interface_phase_lines == pls_pkg::PH_IDLE                     // RL8
                   && rstate_r == pls_pkg::R_NONE && !rx_go;
  assign st_cont = st_act_r && st_cnt_r != st_last_r && !rx_go; // RL12
  assign st_done = st_act_r && st_cnt_r == pls_pkg::ST_LAST_LONG && !rx_go;
  assign flag_clr = (st_go ? 4'h3 : 4'h0)
                  | ((st_cont && st_cnt_r == 3'h0) ? 4'hc : 4'h0);

  // Receive state, next value
  always_comb begin
    rstate_nxt = rstate_r;
    case (rstate_r)
      pls_pkg::R_NONE: begin
        if (rx_go) begin
          rstate_nxt = pls_pkg::R_DON; // RL11 RL19
        end
      end
      pls_pkg::R_DON: begin
        if (rx_end) begin
          rstate_nxt = pls_pkg::R_GAP; // RL15
        end else if (rx_valid) begin
          rstate_nxt = pls_pkg::R_SPD; // RL16
        end
      end
      pls_pkg::R_SPD: begin
        rstate_nxt = pls_pkg::R_DATA; // RL13
      end
      pls_pkg::R_DATA: begin
        if (!byte_take && rx_end) begin
          rstate_nxt = pls_pkg::R_GAP;
        end
      end
      default: begin
        rstate_nxt = pls_pkg::R_NONE; // RL14
      end
    endcase
  end

  // Output lines, next value; receive has priority over status
  always_comb begin
    phase_nxt = pls_pkg::PH_IDLE; // RL22
    d_nxt     = 8'h00;
    case (rstate_nxt)
      pls_pkg::R_DON: begin
        phase_nxt = pls_pkg::PH_RX; // RL21 RL11
        d_nxt     = pls_pkg::D_DATAON;
      end
      pls_pkg::R_SPD: begin
        phase_nxt = pls_pkg::PH_RX;
        d_nxt     = spd_code(spd_r[1:0]); // RL13
      end
      pls_pkg::R_DATA: begin
        phase_nxt = pls_pkg::PH_RX;
        d_nxt     = byte_take ? rx_byte : link_data;
      end
      pls_pkg::R_GAP: begin
        phase_nxt = pls_pkg::PH_IDLE; // RL14
      end
      default: begin
        if (st_go) begin
          phase_nxt = pls_pkg::PH_STATUS; // RL2
          d_nxt     = {6'h00, flags_r[1:0]};
        end else if (st_cont && st_cnt_r == 3'h0) begin
          phase_nxt = pls_pkg::PH_STATUS; // RL3
          d_nxt     = {6'h00, flags_r[3:2]};
        end else if (st_cont) begin
          phase_nxt = pls_pkg::PH_STATUS; // RL4
          d_nxt     = {6'h00, sh_r[1:0]};
        end
      end
    endcase
  end

  // Interface pins, registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      interface_phase_lines <= pls_pkg::PH_IDLE;
      link_data             <= 8'h00;
    end else begin
      interface_phase_lines <= phase_nxt;
      link_data             <= d_nxt;
    end
  end

  // Receive state and handshakes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rstate_r       <= pls_pkg::R_NONE;
      rx_start_ready <= 1'b0;
      rx_ready       <= 1'b0;
      spd_r          <= pls_pkg::SPD_S100;
    end else begin
      rstate_r       <= rstate_nxt;
      rx_start_ready <= rstate_nxt == pls_pkg::R_NONE;
      rx_ready       <= rstate_nxt == pls_pkg::R_SPD || rstate_nxt == pls_pkg::R_DATA;
      if (rx_go) begin
        spd_r <= {6'h00, rx_speed};
      end
    end
  end

  // Status transfer progress; a receive aborts it and retry follows
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_act_r  <= 1'b0;
      st_cnt_r  <= 3'h0;
      st_last_r <= pls_pkg::ST_LAST_SHORT;
      sh_r      <= 12'h000;
    end else if (st_go) begin
      st_act_r  <= 1'b1;
      st_cnt_r  <= 3'h0;
      st_last_r <= reg_pend_r ? pls_pkg::ST_LAST_LONG : pls_pkg::ST_LAST_SHORT; // RL4
      sh_r      <= {reg_data_r, reg_addr_r}; // RL9
    end else if (st_cont) begin
      st_cnt_r <= st_cnt_r + 3'h1;
      if (st_cnt_r != 3'h0) begin
        sh_r <= {2'h0, sh_r[11:2]};
      end
    end else begin
      st_act_r <= 1'b0; // RL7
    end
  end

  // Packets forwarded, null packets included
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pkts_r <= 32'h0;
    end else if (rstate_nxt == pls_pkg::R_GAP && rstate_r != pls_pkg::R_GAP) begin
      pkts_r <= pkts_r + 32'h1;
    end
  end

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  // Both write channels are taken together; simpler than buffering one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= pls_pkg::RESP_OKAY;
      ctrl_r        <= pls_pkg::CTRL_RST;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
        s_axi_bvalid  <= 1'b1;
        s_axi_bresp   <= pls_pkg::RESP_OKAY;
        if (s_axi_awaddr[3:0] == pls_pkg::OFS_CTRL && s_axi_awaddr[31:4] == 28'h0) begin
          if (s_axi_wstrb[0]) begin
            ctrl_r[0] <= s_axi_wdata[0];
          end
        end else if (s_axi_awaddr[3:0] == pls_pkg::OFS_STAT && s_axi_awaddr[31:4] == 28'h0) begin
          s_axi_bresp <= pls_pkg::RESP_OKAY;
        end else if (s_axi_awaddr[3:0] == pls_pkg::OFS_PKTS && s_axi_awaddr[31:4] == 28'h0) begin
          s_axi_bresp <= pls_pkg::RESP_OKAY;
        end else begin
          s_axi_bresp <= pls_pkg::RESP_SLV;
        end
      end
    end
  end

  // Read channel; unmapped addresses answer SLVERR with zero data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= pls_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= pls_pkg::RESP_OKAY;
        if (s_axi_araddr[3:0] == pls_pkg::OFS_CTRL && s_axi_araddr[31:4] == 28'h0) begin
          s_axi_rdata <= ctrl_r;
        end else if (s_axi_araddr[3:0] == pls_pkg::OFS_STAT && s_axi_araddr[31:4] == 28'h0) begin
          s_axi_rdata <= {25'h0, rstate_r != pls_pkg::R_NONE, st_act_r, reg_pend_r, flags_r};
        end else if (s_axi_araddr[3:0] == pls_pkg::OFS_PKTS && s_axi_araddr[31:4] == 28'h0) begin
          s_axi_rdata <= pkts_r;
        end else begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= pls_pkg::RESP_SLV;
        end
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Helper: length of the current status run
  logic [3:0] st_run_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_run_r <= 4'h0;
    end else if (phase_nxt == pls_pkg::PH_STATUS) begin
      st_run_r <= st_run_r + 4'h1;
    end else begin
      st_run_r <= 4'h0;
    end
  end

  status_from_idle_a: assert property ( // RL1
    $rose(interface_phase_lines == pls_pkg::PH_STATUS)
      |-> $past(interface_phase_lines) == pls_pkg::PH_IDLE && $past(flags_r != 4'h0 || reg_pend_r))
    else $error("status started outside idle");
  status_bits_a: assert property ( // RL2
    interface_phase_lines == pls_pkg::PH_STATUS |-> link_data[7:2] == 6'h00)
    else $error("status drove upper data lines");
  status_len_a: assert property ( // RL4
    st_run_r <= pls_pkg::ST_MAX_CYC)
    else $error("status transfer too long");
  status_gap_a: assert property ( // RL8
    st_act_r && st_cnt_r == 3'h0 |-> $past(interface_phase_lines) == pls_pkg::PH_IDLE)
    else $error("no idle between status transfers");
  reg_done_a: assert property ( // RL6
    $fell(reg_pend_r) |-> $past(st_act_r) && $past(st_cnt_r) == 3'h7
      && $past(interface_phase_lines) == pls_pkg::PH_STATUS)
    else $error("register dropped before all bits sent");
  intr_flag_a: assert property ( // RL10
    (ev.cfg_to || ev.pwr_low || ev.state_to || ev.port_chg) |=> flags_r[3])
    else $error("interrupt flag not raised");
  flag_latch_a: assert property ( // RL23
    ev.arb_gap |=> flags_r[0])
    else $error("event lost");
  rx_dataon_a: assert property ( // RL11
    $rose(interface_phase_lines == pls_pkg::PH_RX) |-> link_data == pls_pkg::D_DATAON ##1
      interface_phase_lines != pls_pkg::PH_RX || link_data == pls_pkg::D_DATAON
      || rstate_r == pls_pkg::R_SPD)
    else $error("receive did not open with data-on");
  spd_once_a: assert property ( // RL13
    rstate_r == pls_pkg::R_SPD |-> link_data == spd_code(spd_r[1:0])
      && $past(link_data) == pls_pkg::D_DATAON ##1 rstate_r == pls_pkg::R_DATA)
    else $error("speed code cycle wrong");
  rx_gap_a: assert property ( // RL14
    $past(interface_phase_lines) == pls_pkg::PH_RX && interface_phase_lines == pls_pkg::PH_IDLE
      |=> interface_phase_lines == pls_pkg::PH_IDLE)
    else $error("no idle after receive");
  null_pkt_a: assert property ( // RL15
    rstate_r == pls_pkg::R_DON && rx_end |=> interface_phase_lines == pls_pkg::PH_IDLE)
    else $error("null packet not closed by idle");

  long_status_c: cover property (
    interface_phase_lines == pls_pkg::PH_STATUS && st_run_r == pls_pkg::ST_MAX_CYC);
  preempt_c: cover property (
    interface_phase_lines == pls_pkg::PH_STATUS ##1 interface_phase_lines == pls_pkg::PH_RX);
  null_c: cover property (rstate_r == pls_pkg::R_DON && rx_end);
  data_c: cover property (rstate_r == pls_pkg::R_DATA && rx_end && !byte_take);
endmodule : pls_link_status_rx
`default_nettype wire

// ---- verilog/pls_pkg.sv ----
`default_nettype none
package pls_pkg;
  // ****************************************
  // Interface phase and data codes
  // ****************************************
  localparam logic [1:0] PH_IDLE   = 2'h0;
  localparam logic [1:0] PH_STATUS = 2'h1;
  localparam logic [1:0] PH_RX     = 2'h2;
  localparam logic [7:0] D_DATAON  = 8'hff;
  localparam logic [7:0] SPD_S100  = 8'h00;
  localparam logic [7:0] SPD_S200  = 8'h40;
  localparam logic [7:0] SPD_S400  = 8'h50;
  // ****************************************
  // Status transfer last counter values (2 or 8 cycles) and length limit in cycles
  // ****************************************
  localparam logic [2:0] ST_LAST_SHORT = 3'h1;
  localparam logic [2:0] ST_LAST_LONG  = 3'h7;
  localparam logic [3:0] ST_MAX_CYC    = 4'h8;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [3:0]  OFS_CTRL   = 4'h0;
  localparam logic [3:0]  OFS_STAT   = 4'h4;
  localparam logic [3:0]  OFS_PKTS   = 4'h8;
  localparam logic [31:0] CTRL_RST   = 32'h0000_0001;
  localparam int          CTRL_EN_B  = 0;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLV   = 2'h2;
  // Physical-ID register address, sent after self-identification
  localparam logic [3:0]  PHYID_ADDR = 4'h0;
  // ****************************************
  // Event carrier from the serial-bus side
  // ****************************************
  typedef struct packed {
    logic port_chg;
    logic state_to;
    logic pwr_low;
    logic cfg_to;
    logic bus_reset;
    logic subact_gap;
    logic arb_gap;
  } pls_ev_t;
  typedef enum logic [2:0] {R_NONE, R_DON, R_SPD, R_DATA, R_GAP} pls_rst_t;
endpackage : pls_pkg
`default_nettype wire

// ---- verification/pls_link_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Link-side receiver of the phase and data lines
// ****************************************
module pls_link_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [1:0]  ph,
  input  wire logic [7:0]  d,
  output logic      [15:0] st_word,
  output logic      [3:0]  st_len,
  output logic             st_cut,
  output logic      [7:0]  st_cnt,
  output logic      [7:0]  rx_spd,
  output logic             rx_seen,
  output logic      [7:0]  rx_n,
  output logic      [7:0]  rx_sum,
  output logic      [7:0]  rx_don,
  output logic      [7:0]  pk_cnt,
  output logic      [7:0]  viol
);
  logic [15:0] w_r;
  logic [3:0]  n_r;
  logic [1:0]  p1_r, p2_r;
  logic        sp_r;
  logic [7:0]  spd_r, last_r, bn_r, sum_r, dn_r;
  // Bytes are counted on change of value, so a stalled source is not counted twice
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {st_word, st_len, st_cut, st_cnt, rx_spd, rx_seen, rx_n, rx_sum, rx_don, pk_cnt, viol} <= '0;
      {w_r, n_r, p1_r, p2_r, sp_r, spd_r, last_r, bn_r, sum_r, dn_r} <= '0;
    end else begin
      p1_r <= ph;
      p2_r <= p1_r;
      if (ph == pls_pkg::PH_STATUS) begin
        if (n_r < 4'h8) w_r[2*n_r +: 2] <= d[1:0];
        n_r <= n_r + 4'h1;
      end else if (p1_r == pls_pkg::PH_STATUS) begin
        st_word <= w_r;
        st_len  <= n_r;
        st_cut  <= (ph == pls_pkg::PH_RX);
        st_cnt  <= st_cnt + 8'h1;
        w_r     <= '0;
        n_r     <= '0;
      end
      if (ph == pls_pkg::PH_RX) begin
        if (!sp_r && d == pls_pkg::D_DATAON) dn_r <= dn_r + 8'h1;
        else if (!sp_r) begin
          spd_r  <= d;
          last_r <= d;
          sp_r   <= 1'b1;
        end else if (d != last_r) begin
          bn_r   <= bn_r + 8'h1;
          sum_r  <= sum_r + d;
          last_r <= d;
        end
      end else if (p1_r == pls_pkg::PH_RX) begin
        {rx_spd, rx_seen, rx_n, rx_sum, rx_don} <= {spd_r, sp_r, bn_r, sum_r, dn_r};
        pk_cnt <= pk_cnt + 8'h1;
        {sp_r, bn_r, sum_r, dn_r} <= '0;
      end
      // Idle must last two cycles after receive; code 11 is never driven
      if ((p2_r == pls_pkg::PH_RX && p1_r == pls_pkg::PH_IDLE && ph != pls_pkg::PH_IDLE) || ph == 2'h3)
        viol <= viol + 8'h1;
    end
  end
endmodule : pls_link_model
`default_nettype wire

// ---- verification/pls_link_status_rx_test.sv ----
`timescale 1ns/100ps
`default_nettype none
module pls_link_status_rx_test;
  // ****************************************
  // Signals
  // ****************************************
  logic             aclk, aresetn, rd_req, selfid_done, rx_start, rx_valid, rx_end;
  pls_pkg::pls_ev_t ev;
  logic [3:0]       rd_addr, st_len;
  logic [7:0]       rd_data, phyid_data, rx_byte, ldata, st_cnt, rx_spd, rx_n, rx_sum, rx_don, pk_cnt, viol, sum;
  logic [1:0]       rx_speed, phl, br, rr, r;
  logic             rx_start_ready, rx_ready, awv, awr, wv, wr, bv, bre, arv, arr, rv, rre, st_cut, rx_seen;
  logic [31:0]      awa, wda, ara, rd, v;
  logic [15:0]      st_word, s;
  int               failures, compares;
  typedef struct packed {logic [6:0] e; logic [3:0] w;} pls_row_t;
  pls_row_t         rows [9];
  logic [7:0]       spd_tab [4];

  pls_link_status_rx pls_link_status_rx_i (.aclk(aclk), .aresetn(aresetn), .ev(ev), .rd_req(rd_req),
    .rd_addr(rd_addr), .rd_data(rd_data), .selfid_done(selfid_done), .phyid_data(phyid_data),
    .rx_start(rx_start), .rx_speed(rx_speed), .rx_start_ready(rx_start_ready), .rx_valid(rx_valid),
    .rx_byte(rx_byte), .rx_ready(rx_ready), .rx_end(rx_end), .interface_phase_lines(phl), .link_data(ldata),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wda), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr),
    .s_axi_rvalid(rv), .s_axi_rready(rre));
  pls_link_model pls_link_model_i (.aclk(aclk), .aresetn(aresetn), .ph(phl), .d(ldata), .st_word(st_word),
    .st_len(st_len), .st_cut(st_cut), .st_cnt(st_cnt), .rx_spd(rx_spd), .rx_seen(rx_seen), .rx_n(rx_n),
    .rx_sum(rx_sum), .rx_don(rx_don), .pk_cnt(pk_cnt), .viol(viol));

  // Clock at 40 MHz
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic give_verdict();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Each bus task starts on a fresh edge so no signal is driven twice in one step
  task automatic axw(input logic [31:0] a, input logic [31:0] d, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge aclk);
    awa <= a;
    wda <= d;
    awv <= 1'b1;
    wv  <= 1'b1;
    bre <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awr === 1'b1) awv <= 1'b0;
      if (wr === 1'b1) wv <= 1'b0;
    end while (bv !== 1'b1 && n < 50);
    if (bv !== 1'b1) failures++;
    rs = br;
    bre <= 1'b0;
  endtask : axw
  task automatic axr(input logic [31:0] a, output logic [31:0] d, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arr === 1'b1) arv <= 1'b0;
    end while (rv !== 1'b1 && n < 50);
    if (rv !== 1'b1) failures++;
    d = rd;
    rs = rr;
    rre <= 1'b0;
  endtask : axr
  task automatic pulse(input logic [6:0] e);
    @(posedge aclk);
    ev <= e;
    @(posedge aclk);
    ev <= '0;
  endtask : pulse
  // Bounded wait for the link model to record a finished transfer
  task automatic wait_chg(input logic [15:0] s0);
    int n;
    n = 0;
    while ({st_cnt, pk_cnt} === s0 && n < 300) begin
      @(posedge aclk);
      n++;
    end
    if ({st_cnt, pk_cnt} === s0) failures++;
  endtask : wait_chg
  // Packet bytes are distinct and never all ones; byte k is 21h times k+1
  task automatic rxpkt(input logic [1:0] sp, input int nb);
    int n, k;
    logic [7:0] p0;
    n = 0;
    k = 0;
    p0 = pk_cnt;
    @(posedge aclk);
    rx_start <= 1'b1;
    rx_speed <= sp;
    do begin
      @(posedge aclk);
      n++;
    end while (rx_start_ready !== 1'b1 && n < 100);
    rx_start <= 1'b0;
    rx_valid <= (nb > 0);
    rx_byte  <= 8'h21;
    while (k < nb && n < 200) begin
      @(posedge aclk);
      n++;
      if (rx_ready === 1'b1) k++;
      rx_byte <= 8'(8'h21 * (k + 1));
    end
    rx_valid <= 1'b0;
    rx_end   <= 1'b1;
    @(posedge aclk);
    rx_end <= 1'b0;
    while (pk_cnt === p0 && n < 300) begin
      @(posedge aclk);
      n++;
    end
    if (pk_cnt === p0) failures++;
  endtask : rxpkt
  // Hang guard
  initial begin
    repeat (6000) @(posedge aclk);
    failures++;
    give_verdict();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {aresetn, rd_req, selfid_done, rx_start, rx_valid, rx_end, ev, rd_addr, rd_data, phyid_data} = '0;
    {rx_byte, rx_speed, awa, wda, ara, awv, wv, bre, arv, rre} = '0;
    failures = 0;
    compares = 0;
    rows = '{'{7'h01, 4'h1}, '{7'h02, 4'h2}, '{7'h04, 4'h4}, '{7'h08, 4'h8}, '{7'h10, 4'h8},
             '{7'h20, 4'h8}, '{7'h40, 4'h8}, '{7'h07, 4'h7}, '{7'h78, 4'h8}};
    spd_tab = '{pls_pkg::SPD_S100, pls_pkg::SPD_S200, pls_pkg::SPD_S400, pls_pkg::SPD_S100};
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("phase", {30'h0, pls_pkg::PH_IDLE}, {30'h0, phl});
    axr({28'h0, pls_pkg::OFS_CTRL}, v, r);
    chk("ctrl", pls_pkg::CTRL_RST, v);
    axr({28'h0, pls_pkg::OFS_PKTS}, v, r);
    chk("pkts", 32'h0, v);
    // Flag events, one transfer of two cycles each
    foreach (rows[i]) begin
      s = {st_cnt, pk_cnt};
      pulse(rows[i].e);
      wait_chg(s);
      chk("flag word", {28'h0, rows[i].w}, {16'h0, st_word});
      chk("flag len", 32'h2, {28'h0, st_len});
    end
    // Register read and physical id after self identification
    s = {st_cnt, pk_cnt};
    @(posedge aclk);
    {rd_req, rd_addr, rd_data} <= {1'b1, 4'h9, 8'ha5};
    @(posedge aclk);
    rd_req <= 1'b0;
    wait_chg(s);
    chk("reg word", 32'ha590, {16'h0, st_word});
    chk("reg len", 32'h8, {28'h0, st_len});
    s = {st_cnt, pk_cnt};
    @(posedge aclk);
    {selfid_done, phyid_data} <= {1'b1, 8'h3c};
    @(posedge aclk);
    selfid_done <= 1'b0;
    wait_chg(s);
    chk("id word", {16'h0, 8'h3c, pls_pkg::PHYID_ADDR, 4'h0}, {16'h0, st_word});
    // A second event during a transfer needs its own transfer after idle
    s = {st_cnt, pk_cnt};
    pulse(7'h01);
    pulse(7'h02);
    wait_chg(s);
    s = {st_cnt, pk_cnt};
    wait_chg(s);
    chk("second word", 32'h2, {16'h0, st_word});
    chk("second len", 32'h2, {28'h0, st_len});
    // Receive at every speed code, then a null packet
    for (int k = 0; k < 4; k++) begin
      sum = '0;
      for (int b = 0; b <= k; b++) sum = sum + 8'(8'h21 * (b + 1));
      rxpkt(2'(k), k + 1);
      chk("speed", {24'h0, spd_tab[k]}, {24'h0, rx_spd});
      chk("bytes", k + 1, {24'h0, rx_n});
      chk("sum", {24'h0, sum}, {24'h0, rx_sum});
      chk("dataon", 32'h1, {31'h0, rx_don != 8'h0});
    end
    rxpkt(2'h0, 0);
    chk("null speed", 32'h0, {31'h0, rx_seen});
    chk("null dataon", 32'h1, {31'h0, rx_don != 8'h0});
    // Receive cuts a register transfer; only the register is retried
    s = {st_cnt, pk_cnt};
    @(posedge aclk);
    {rd_req, rd_addr, rd_data, ev} <= {1'b1, 4'h5, 8'h77, 7'h01};
    @(posedge aclk);
    {rd_req, ev} <= '0;
    for (int n = 0; n < 20 && phl !== pls_pkg::PH_STATUS; n++) @(posedge aclk);
    repeat (2) @(posedge aclk);
    rxpkt(2'h2, 2);
    chk("cut", 32'h1, {31'h0, st_cut});
    s = {st_cnt, pk_cnt};
    wait_chg(s);
    chk("retry word", 32'h7750, {16'h0, st_word});
    chk("retry len", 32'h8, {28'h0, st_len});
    // Disabled status holds the flag pending
    axw({28'h0, pls_pkg::OFS_CTRL}, 32'h0, r);
    s = {st_cnt, pk_cnt};
    pulse(7'h04);
    repeat (20) @(posedge aclk);
    chk("held", {16'h0, s}, {16'h0, st_cnt, pk_cnt});
    axr({28'h0, pls_pkg::OFS_STAT}, v, r);
    chk("stat", 32'h4, v);
    axw({28'h0, pls_pkg::OFS_CTRL}, 32'h1, r);
    wait_chg(s);
    chk("late word", 32'h4, {16'h0, st_word});
    axr({28'h0, pls_pkg::OFS_PKTS}, v, r);
    chk("pkts", 32'h6, v);
    axw({28'h0, pls_pkg::OFS_STAT}, 32'hf, r);
    chk("ro write", {30'h0, pls_pkg::RESP_OKAY}, {30'h0, r});
    axw(32'h10, 32'h1, r);
    chk("bad write", {30'h0, pls_pkg::RESP_SLV}, {30'h0, r});
    axr(32'h10, v, r);
    chk("bad read", {30'h0, pls_pkg::RESP_SLV}, {30'h0, r});
    chk("bad data", 32'h0, v);
    chk("violations", 32'h0, {24'h0, viol});
    give_verdict();
  end
endmodule : pls_link_status_rx_test
`default_nettype wire
